// ==== core/tmr0_pkg.sv ====
// Purpose: constants and carrier types for the asynchronous 8-bit timer block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: all reset values are zero
package tmr0_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_GEN_CTRL = 8'h23;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h6e;
  localparam logic [7:0] IDX_ASYNC_STAT = 8'hb6;
  localparam logic [7:0] IDX_COUNT = 8'h27;
  localparam logic [7:0] IDX_COMPARE = 8'h28;
  localparam logic [7:0] IDX_CTRL_A = 8'h25;
  localparam logic [7:0] IDX_CTRL_B = 8'h26;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h35;
  localparam logic [7:0] IDX_CPU_STATUS = 8'h3f;

  // Field positions
  localparam int BIT_EXT_CLK = 6;
  localparam int BIT_ASYNC = 5;
  localparam int BIT_CNT_BUSY = 4;
  localparam int BIT_CMP_BUSY = 3;
  localparam int BIT_CTA_BUSY = 1;
  localparam int BIT_CTB_BUSY = 0;
  localparam int BIT_HOLD = 7;
  localparam int BIT_PRE_RST = 1;
  localparam int BIT_PRE_RST_OTHER = 0;
  localparam int BIT_IRQ_CMP = 1;
  localparam int BIT_IRQ_OVF = 0;
  localparam int BIT_GIE = 7;

  // Writable field masks of the control registers
  localparam logic [7:0] CTRL_A_MASK = 8'hc3;
  localparam logic [7:0] CTRL_B_MASK = 8'h07;

  // Values after reset and counter limits
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam int PRE_W = 10;

  // Counting modes (waveform generation field of control A)
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE = 2'b01,
    MODE_CTC = 2'b10,
    MODE_FAST = 2'b11
  } timer_mode_t;

  // Avalon-MM request and answer
  typedef struct packed {
    logic read;
    logic write;
    logic [9:0] address;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } av_rsp_t;

endpackage

// ==== core/tmr0_async_core.sv ====
// Purpose: register file, prescaler, 8-bit counter and flags of the async timer
// Assumes: async timer clock and system-clock-source status arrive as pins
// Notes: async writes go to holding registers and land on a timer clock edge
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps

// Function
// - External clock buffer on, oscillator only otherwise
// - Select zero: counting from the system clock
// - Select one: counting from crystal or external clock
// - Select stays one only on RC clocks
// - Async count write sets busy until loaded
// - Async compare write sets busy until transferred
// - Async control A write sets busy until transferred
// - Async control B write sets busy until transferred
// - Count reads live, others read holding register
// - Compare interrupt needs enable, global, flag
// - Overflow interrupt needs enable, global, flag
// - Compare flag sets on match, clears acknowledged
// - Overflow flag sets on overflow, clears acknowledged
// - Phase mode overflow at bottom direction change
// - Prescaler reset bit clears right after reset
// - Async prescaler reset reads one until done
// - Hold mode keeps prescaler reset bit set
// - Reserved mask and flag bits read zero
// - Leaving hold mode clears both reset bits
module tmr0_async_core #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Register bus
  input wire tmr0_pkg::av_req_t AV_REQ_I,
  output tmr0_pkg::av_rsp_t AV_RSP_O,
  // Clock source pins
  input wire logic ASYNC_CLK_I,
  input wire logic SYS_CLK_IS_RC_I,
  // Interrupt vector taken: bit 1 compare, bit 0 overflow
  input wire logic [1:0] IRQ_ACK_I,
  // Interrupt requests and oscillator controls
  output logic [1:0] IRQ_O,
  output logic XOSC_EN_O,
  output logic EXT_CLK_BUF_EN_O
);
  import tmr0_pkg::*;

  if (ADDR_W != 10) begin : g_chk
    $error("ADDR_W must match the 10-bit request address");
  end

  typedef struct packed {
    logic aclk_s1, aclk_s2, aclk_s3;
    logic rc_s1, rc_s2;
    logic wait_q;
    logic [7:0] rdata;
    logic ext_en, as_sel;
    logic cnt_busy, cmp_busy, cta_busy, ctb_busy;
    logic [7:0] count, cnt_tmp, cmp_act, cmp_tmp, cta_act, cta_tmp, ctb_act, ctb_tmp;
    logic dir_down, cmp_block;
    logic hold, pre_rst, pre_rst_other;
    logic [PRE_W-1:0] pre;
    logic [1:0] irq_en, flags;
    logic gie;
    logic [1:0] irq;
    logic xosc, extbuf;
  } state_t;

  state_t s_q, s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic req, wr_take, rd_take, src_edge, src_tick, tick, match;
  logic [7:0] idx, wd, rmux;
  logic [PRE_W-1:0] tap_mask;
  logic [1:0] flag_set, flag_clr;
  timer_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and timer clock enables
  assign req = AV_REQ_I.read | AV_REQ_I.write;
  assign wr_take = AV_REQ_I.write && !s_q.wait_q;
  assign rd_take = AV_REQ_I.read && !s_q.wait_q;
  assign idx = AV_REQ_I.address[9:2];
  assign wd = AV_REQ_I.writedata[7:0];
  assign mode = timer_mode_t'(s_q.cta_act[1:0]);
  assign src_edge = s_q.aclk_s2 & ~s_q.aclk_s3;
  assign src_tick = s_q.as_sel ? src_edge : 1'b1;

  // Prescaler tap for the clock select code
  always_comb begin
    unique case (s_q.ctb_act[2:0])
      3'h1: tap_mask = 10'h000;
      3'h2: tap_mask = 10'h007;
      3'h3: tap_mask = 10'h01f;
      3'h4: tap_mask = 10'h03f;
      3'h5: tap_mask = 10'h07f;
      3'h6: tap_mask = 10'h0ff;
      3'h7: tap_mask = 10'h3ff;
      default: tap_mask = 10'h000;
    endcase
  end
  assign tick = src_tick && !s_q.pre_rst && (s_q.ctb_act[2:0] != 3'h0)
    && ((s_q.pre & tap_mask) == tap_mask);
  assign match = tick && (s_q.count == s_q.cmp_act) && !s_q.cmp_block;

  // read mux, holding registers for compare and controls
  always_comb begin
    unique case (idx)
      IDX_GEN_CTRL: rmux = {s_q.hold, 5'h00, s_q.pre_rst, s_q.pre_rst_other};
      IDX_IRQ_MASK: rmux = {6'h00, s_q.irq_en};
      IDX_IRQ_FLAGS: rmux = {6'h00, s_q.flags};
      IDX_ASYNC_STAT: rmux = {1'b0, s_q.ext_en, s_q.as_sel, s_q.cnt_busy, s_q.cmp_busy,
                              1'b0, s_q.cta_busy, s_q.ctb_busy};
      IDX_COUNT: rmux = s_q.count;
      IDX_COMPARE: rmux = s_q.cmp_tmp;
      IDX_CTRL_A: rmux = s_q.cta_tmp;
      IDX_CTRL_B: rmux = s_q.ctb_tmp;
      IDX_CPU_STATUS: rmux = {s_q.gie, 7'h00};
      default: rmux = RESET_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    flag_set = 2'b00;
    flag_clr = IRQ_ACK_I;
    // Pin synchronisers
    s_d.aclk_s1 = ASYNC_CLK_I;
    s_d.aclk_s2 = s_q.aclk_s1;
    s_d.aclk_s3 = s_q.aclk_s2;
    s_d.rc_s1 = SYS_CLK_IS_RC_I;
    s_d.rc_s2 = s_q.rc_s1;
    // Bus handshake: one wait cycle, then answer
    if (req && s_q.wait_q) begin
      s_d.wait_q = 1'b0;
      s_d.rdata = rmux;
    end else begin
      s_d.wait_q = 1'b1;
    end
    // prescaler reset held in hold mode, else cleared on source tick
    if (s_q.pre_rst) begin
      s_d.pre = '0;
      if (!s_q.hold && src_tick) begin
        s_d.pre_rst = 1'b0;
      end
    end else if (src_tick) begin
      s_d.pre = s_q.pre + 1'b1;
    end
    // other timer's reset bit held in hold mode, else cleared on the next clock without waiting for a source tick
    if (s_q.pre_rst_other && !s_q.hold) begin
      s_d.pre_rst_other = 1'b0;
    end
    // Counter stepping
    if (tick) begin
      s_d.cmp_block = 1'b0;
      unique case (mode)
        MODE_PHASE: begin
          if (s_q.dir_down) begin
            s_d.count = s_q.count - 1'b1;
            if (s_q.count == COUNT_BOTTOM) begin
              s_d.count = s_q.count + 1'b1;
              s_d.dir_down = 1'b0;
              flag_set[BIT_IRQ_OVF] = 1'b1;
            end
          end else if (s_q.count == COUNT_MAX) begin
            s_d.count = s_q.count - 1'b1;
            s_d.dir_down = 1'b1;
          end else begin
            s_d.count = s_q.count + 1'b1;
          end
        end
        MODE_CTC: begin
          s_d.count = match ? COUNT_BOTTOM : s_q.count + 1'b1;
          flag_set[BIT_IRQ_OVF] = (s_q.count == COUNT_MAX);
        end
        MODE_NORMAL, MODE_FAST: begin
          s_d.count = s_q.count + 1'b1;
          flag_set[BIT_IRQ_OVF] = (s_q.count == COUNT_MAX);
        end
      endcase
    end
    flag_set[BIT_IRQ_CMP] = match;
    // transfer from holding registers on the async edge
    if (s_q.as_sel && src_edge) begin
      if (s_q.cnt_busy) begin
        s_d.count = s_q.cnt_tmp;
        s_d.cnt_busy = 1'b0;
      end
      if (s_q.cmp_busy) begin
        s_d.cmp_act = s_q.cmp_tmp;
        s_d.cmp_busy = 1'b0;
      end
      if (s_q.cta_busy) begin
        s_d.cta_act = s_q.cta_tmp;
        s_d.cta_busy = 1'b0;
      end
      if (s_q.ctb_busy) begin
        s_d.ctb_act = s_q.ctb_tmp;
        s_d.ctb_busy = 1'b0;
      end
    end
    // Register writes take effect on the answering edge
    if (wr_take) begin
      unique case (idx)
        IDX_GEN_CTRL: begin
          s_d.hold = wd[BIT_HOLD];
          s_d.pre_rst = wd[BIT_PRE_RST];
          s_d.pre_rst_other = wd[BIT_PRE_RST_OTHER];
          // leaving hold releases both prescalers together
          if (s_q.hold && !wd[BIT_HOLD]) begin
            s_d.pre_rst = 1'b0;
            s_d.pre_rst_other = 1'b0;
          end
        end
        IDX_IRQ_MASK: s_d.irq_en = wd[1:0];
        IDX_IRQ_FLAGS: flag_clr = flag_clr | wd[1:0];
        IDX_ASYNC_STAT: begin
          s_d.ext_en = wd[BIT_EXT_CLK];
          // async select kept only on RC system clock
          s_d.as_sel = wd[BIT_ASYNC] & s_q.rc_s2;
        end
        IDX_CPU_STATUS: s_d.gie = wd[BIT_GIE];
        IDX_COUNT: begin
          s_d.cnt_tmp = wd;
          s_d.cmp_block = 1'b1;
          if (s_q.as_sel) begin
            s_d.cnt_busy = 1'b1;
          end else begin
            s_d.count = wd;
          end
        end
        IDX_COMPARE: begin
          s_d.cmp_tmp = wd;
          if (s_q.as_sel) begin
            s_d.cmp_busy = 1'b1;
          end else begin
            s_d.cmp_act = wd;
          end
        end
        IDX_CTRL_A: begin
          s_d.cta_tmp = wd & CTRL_A_MASK;
          if (s_q.as_sel) begin
            s_d.cta_busy = 1'b1;
          end else begin
            s_d.cta_act = wd & CTRL_A_MASK;
          end
        end
        IDX_CTRL_B: begin
          s_d.ctb_tmp = wd & CTRL_B_MASK;
          if (s_q.as_sel) begin
            s_d.ctb_busy = 1'b1;
          end else begin
            s_d.ctb_act = wd & CTRL_B_MASK;
          end
        end
        default: ;
      endcase
    end
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
    s_d.irq = s_q.irq_en & s_q.flags & {2{s_q.gie}} & ~flag_clr;
    s_d.xosc = s_q.as_sel & ~s_q.ext_en;
    s_d.extbuf = s_q.as_sel & s_q.ext_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.wait_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign AV_RSP_O = '{waitrequest: s_q.wait_q, readdata: {24'h000000, s_q.rdata}};
  assign IRQ_O = s_q.irq;
  assign XOSC_EN_O = s_q.xosc;
  assign EXT_CLK_BUF_EN_O = s_q.extbuf;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_wr_async(logic [7:0] i);
    wr_take && idx == i && s_q.as_sel;
  endsequence

  property p_ext_buf;
    @(posedge CLK_I) disable iff (!rst_n)
      ##1 (EXT_CLK_BUF_EN_O == $past(s_q.as_sel & s_q.ext_en))
      && !(XOSC_EN_O && EXT_CLK_BUF_EN_O);
  endproperty
  a_ext_buf: assert property (p_ext_buf) else $error("clock buffer enable wrong");

  property p_as_norc;
    @(posedge CLK_I) disable iff (!rst_n)
      (wr_take && idx == IDX_ASYNC_STAT && !s_q.rc_s2) |=> !s_q.as_sel;
  endproperty
  a_as_norc: assert property (p_as_norc) else $error("async select kept on non-RC");

  property p_cnt_busy;
    @(posedge CLK_I) disable iff (!rst_n)
      s_wr_async(IDX_COUNT) |=> s_q.cnt_busy && s_q.cnt_tmp == $past(wd);
  endproperty
  a_cnt_busy: assert property (p_cnt_busy) else $error("count busy not set");

  property p_cmp_busy_clr;
    @(posedge CLK_I) disable iff (!rst_n)
      (s_q.cmp_busy && s_q.as_sel && src_edge && !wr_take) |=>
        !s_q.cmp_busy && s_q.cmp_act == $past(s_q.cmp_tmp);
  endproperty
  a_cmp_busy_clr: assert property (p_cmp_busy_clr) else $error("compare not transferred");

  property p_sync_step;
    @(posedge CLK_I) disable iff (!rst_n)
      (!s_q.as_sel && s_q.ctb_act[2:0] == 3'h1 && !s_q.pre_rst && mode == MODE_NORMAL
       && !wr_take) |=> s_q.count == $past(s_q.count) + 8'h01;
  endproperty
  a_sync_step: assert property (p_sync_step) else $error("sync count did not step");

  property p_irq_cmp;
    @(posedge CLK_I) disable iff (!rst_n)
      (s_q.irq_en[1] && s_q.gie && s_q.flags[1] && !IRQ_ACK_I[1] && !wr_take) |=> IRQ_O[1];
  endproperty
  a_irq_cmp: assert property (p_irq_cmp) else $error("compare interrupt missing");

  property p_irq_gate;
    @(posedge CLK_I) disable iff (!rst_n)
      IRQ_O[0] |-> $past(s_q.irq_en[0] && s_q.gie && s_q.flags[0]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("overflow interrupt ungated");

  property p_match_flag;
    @(posedge CLK_I) disable iff (!rst_n)
      match |=> s_q.flags[1];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set");

  property p_psr_sync;
    @(posedge CLK_I) disable iff (!rst_n)
      (s_q.pre_rst && !s_q.hold && !s_q.as_sel && !wr_take) |=> !s_q.pre_rst;
  endproperty
  a_psr_sync: assert property (p_psr_sync) else $error("prescaler reset not cleared");

  property p_psr_hold;
    @(posedge CLK_I) disable iff (!rst_n)
      (s_q.pre_rst && s_q.hold && !wr_take) |=> s_q.pre_rst && s_q.pre == '0;
  endproperty
  a_psr_hold: assert property (p_psr_hold) else $error("held reset released");

  property p_rsvd;
    @(posedge CLK_I) disable iff (!rst_n)
      (rd_take && (idx == IDX_IRQ_MASK || idx == IDX_IRQ_FLAGS)) |->
        AV_RSP_O.readdata[7:2] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  property p_w0_keep;
    @(posedge CLK_I) disable iff (!rst_n)
      (wr_take && idx == IDX_IRQ_FLAGS && wd[1:0] == 2'b00 && IRQ_ACK_I == 2'b00)
        |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags);
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");

  property p_hold_exit;
    @(posedge CLK_I) disable iff (!rst_n)
      (wr_take && idx == IDX_GEN_CTRL && s_q.hold && !wd[BIT_HOLD]) |=>
        !s_q.pre_rst && !s_q.pre_rst_other;
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("hold exit kept reset bits");

endmodule

// ==== verif/async_timer0_status_irq_test.sv ====
// Purpose: self-checking bench for the async timer register, flag and interrupt logic
// Assumes: registers reached over Avalon-MM, one byte per word, index = address[9:2]
// Notes: the slow timer clock is stepped by hand so every transfer point is known
`timescale 1ns/10ps

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module async_timer0_status_irq_test;
  import tmr0_pkg::*;

  logic clk_i;
  logic rst_n_i;
  av_req_t av_req;
  av_rsp_t av_rsp;
  logic async_clk;
  logic sys_clk_is_rc;
  logic [1:0] irq_ack;
  logic [1:0] irq;
  logic xosc_en;
  logic ext_buf_en;
  int errors;
  int comparisons;
  logic [7:0] rd;

  ////////////////////////////////////////////////////////////////////////////////
  // Device under test
  tmr0_async_core #(.ADDR_W(10)) i_dut (
    .CLK_I(clk_i),
    .RST_N_I(rst_n_i),
    .AV_REQ_I(av_req),
    .AV_RSP_O(av_rsp),
    .ASYNC_CLK_I(async_clk),
    .SYS_CLK_IS_RC_I(sys_clk_is_rc),
    .IRQ_ACK_I(irq_ack),
    .IRQ_O(irq),
    .XOSC_EN_O(xosc_en),
    .EXT_CLK_BUF_EN_O(ext_buf_en)
  );

  // Clock at 200 MHz
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] data);
    int n;
    @(posedge clk_i);
    av_req.read <= ~wr;
    av_req.write <= wr;
    av_req.address <= {idx, 2'b00};
    av_req.writedata <= {24'h000000, data};
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (av_rsp.waitrequest === 1'b0) begin
        break;
      end
    end
    if (n == 50) begin
      errors++;
      conclude();
    end
    rd = av_rsp.readdata[7:0];
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    bus(1'b1, idx, data);
  endtask

  // Read a register and compare its low byte
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK(rd, exp)
  endtask

  // Full periods of the slow timer clock, count of them, each long enough for the synchronizer
  task automatic tick(input int count);
    repeat (count) begin
      @(posedge clk_i);
      async_clk <= 1'b1;
      repeat (6) @(posedge clk_i);
      async_clk <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask

  task automatic cycles(input int count);
    repeat (count) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    av_req = '0;
    async_clk = 1'b0;
    sys_clk_is_rc = 1'b0;
    irq_ack = 2'b00;
    cycles(2);
    rst_n_i <= 1'b1;
    cycles(3);
    // Reset values and reserved bits
    rd_chk(IDX_GEN_CTRL, 8'h00);
    rd_chk(IDX_IRQ_MASK, 8'h00);
    rd_chk(IDX_ASYNC_STAT, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_IRQ_MASK, 8'hff);
    rd_chk(IDX_IRQ_MASK, 8'h03);
    wr(8'h00, 8'h5a);
    rd_chk(8'h00, 8'h00);
    // Synchronous mode: writes land at once, no busy
    wr(IDX_COMPARE, 8'h33);
    rd_chk(IDX_ASYNC_STAT, 8'h00);
    rd_chk(IDX_COMPARE, 8'h33);
    // Synchronous counting: three system clock ticks between the two control writes
    wr(IDX_COUNT, 8'h40);
    wr(IDX_CTRL_B, 8'h01);
    wr(IDX_CTRL_B, 8'h00);
    rd_chk(IDX_COUNT, 8'h43);
    // Clear-on-match mode wraps at the compare value and, started below it, never overflows
    wr(IDX_CTRL_A, 8'h02);
    wr(IDX_COUNT, 8'h30);
    wr(IDX_CTRL_B, 8'h01);
    cycles(300);
    wr(IDX_CTRL_B, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 8'h02);
    wr(IDX_IRQ_FLAGS, 8'h03);
    // Phase mode: no overflow at the top, overflow at the bottom turn
    wr(IDX_CTRL_A, 8'h01);
    wr(IDX_COUNT, 8'hf0);
    wr(IDX_CTRL_B, 8'h01);
    cycles(100);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    cycles(200);
    rd_chk(IDX_IRQ_FLAGS, 8'h03);
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h03);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_GEN_CTRL, 8'h02);
    rd_chk(IDX_GEN_CTRL, 8'h00);
    // Hold mode keeps both reset bits until it is left
    wr(IDX_GEN_CTRL, 8'h83);
    cycles(5);
    rd_chk(IDX_GEN_CTRL, 8'h83);
    wr(IDX_GEN_CTRL, 8'h03);
    rd_chk(IDX_GEN_CTRL, 8'h00);
    // Async select refused while the system clock is not an RC source
    wr(IDX_ASYNC_STAT, 8'h20);
    rd_chk(IDX_ASYNC_STAT, 8'h00);
    `CHK(xosc_en, 1'b0)
    // External clock buffer path, enable set before select
    sys_clk_is_rc <= 1'b1;
    cycles(3);
    wr(IDX_ASYNC_STAT, 8'h40);
    wr(IDX_ASYNC_STAT, 8'h60);
    cycles(2);
    rd_chk(IDX_ASYNC_STAT, 8'h60);
    `CHK(ext_buf_en, 1'b1)
    `CHK(xosc_en, 1'b0)
    // Crystal path
    wr(IDX_ASYNC_STAT, 8'h20);
    cycles(2);
    `CHK(ext_buf_en, 1'b0)
    `CHK(xosc_en, 1'b1)
    // Rewrite the timer registers after the select change; all four go busy
    wr(IDX_COUNT, 8'hfc);
    wr(IDX_COMPARE, 8'hfe);
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_CTRL_B, 8'h01);
    rd_chk(IDX_ASYNC_STAT, 8'h3b);
    rd_chk(IDX_COMPARE, 8'hfe);
    rd_chk(IDX_CTRL_B, 8'h01);
    tick(1);
    rd_chk(IDX_ASYNC_STAT, 8'h20);
    // Count through the match and the wrap, then stop
    tick(5);
    wr(IDX_CTRL_B, 8'h00);
    tick(1);
    rd_chk(IDX_IRQ_FLAGS, 8'h03);
    // Live count read with the timer stopped
    wr(IDX_COUNT, 8'h55);
    tick(1);
    rd_chk(IDX_COUNT, 8'h55);
    // Async prescaler reset reads one until the slow clock completes it
    wr(IDX_GEN_CTRL, 8'h02);
    cycles(4);
    rd_chk(IDX_GEN_CTRL, 8'h02);
    tick(1);
    rd_chk(IDX_GEN_CTRL, 8'h00);
    // Interrupt gating by enable, global enable and flag
    wr(IDX_CPU_STATUS, 8'h00);
    cycles(3);
    `CHK(irq, 2'b00)
    wr(IDX_CPU_STATUS, 8'h80);
    cycles(3);
    `CHK(irq, 2'b11)
    wr(IDX_IRQ_MASK, 8'h01);
    cycles(3);
    `CHK(irq, 2'b01)
    // Vector execution clears the overflow flag
    @(posedge clk_i);
    irq_ack <= 2'b01;
    @(posedge clk_i);
    irq_ack <= 2'b00;
    cycles(3);
    `CHK(irq, 2'b00)
    rd_chk(IDX_IRQ_FLAGS, 8'h02);
    // Writing zero leaves a flag, writing one clears it
    wr(IDX_IRQ_FLAGS, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 8'h02);
    wr(IDX_IRQ_FLAGS, 8'h02);
    rd_chk(IDX_IRQ_FLAGS, 8'h00);
    conclude();
  end
endmodule
